/* File: design/sac_params.svh */
// Notes on behaviour
// - Conversion starts when the last of enable high, select low, read/convert low arrives.
// - Each start captures length/byte select: high gives 8 bits, low gives 12.
// - After an 8-bit conversion the low bits read as 1000 on a full read.
// - Only length/byte select is latched; other controls act directly.
// - Conversion status is high exactly while a conversion is in progress.
// - While conversion status is high every data output stays off.
// - A start during a conversion neither resets nor restarts it.
// - A start during a conversion recaptures length/byte select and may change length.
// - Outputs drive only with read/convert high, status low, enable high, select low.
// - Width select high drives all twelve outputs and ignores length/byte select.
// - Width select low, length/byte select low drives the eight top result bits.
// - Width select low, length/byte select high drives low nibble, bits 4-7 zero.
// - Byte drivers break before make when switching between bytes.
// - Length/byte select may change at any moment without output malfunction.
// - After a start, two internal clock ticks acquire the input, then it is held.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// ==========================================================
// Timing
`define SAC_CLK_NS       10
`define SAC_SETUP_NS     50
`define SAC_SETUP_CYC    ((`SAC_SETUP_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_TICK_DIV     4
`define SAC_ACQ_TICKS    2'h2

// ==========================================================
// Conversion layout
`define SAC_TOP_BIT      4'hb
`define SAC_LONG_STOP    4'h0
`define SAC_SHORT_STOP   4'h4
`define SAC_SHORT_TAIL   4'h8

// ==========================================================
// Output enable patterns
`define SAC_OE_NONE      12'h000
`define SAC_OE_FULL      12'hfff
`define SAC_OE_HIGH      12'hff0
`define SAC_OE_LOW       12'h0ff

`endif

/* File: design/sac_pkg.sv */
package sac_pkg;

	typedef enum logic [1:0] {SAC_IDLE, SAC_ACQ, SAC_CONV} sac_state_e;

	typedef struct packed {
		logic chip_enable;
		logic chip_select_n;
		logic read_convert;
		logic width_select;
		logic length_byte_select;
	} sac_ctrl_s;

endpackage

/* File: design/sac_out_stage.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sac_params.svh"

module sac_out_stage
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        rd_en,
	input  wire logic        width_select,
	input  wire logic        length_byte_select,
	input  wire logic [11:0] result,
	output logic      [11:0] data_out,
	output logic      [11:0] data_oe
);
	logic [11:0] want_oe;
	logic [11:0] next_data_out;
	logic [11:0] next_data_oe;

	// ==========================================================
	// Enable selection
	always_comb
	begin
		if (!rd_en)
			want_oe = `SAC_OE_NONE;
		else if (width_select)
			want_oe = `SAC_OE_FULL;
		else if (length_byte_select)
			want_oe = `SAC_OE_LOW;
		else
			want_oe = `SAC_OE_HIGH;
		if (!width_select && length_byte_select)
			next_data_out = {8'h00, result[3:0]};
		else
			next_data_out = result;
		// A live select toggle only costs one dead cycle, never a clash
		if (data_oe != `SAC_OE_NONE && want_oe != `SAC_OE_NONE && data_oe != want_oe)
			next_data_oe = `SAC_OE_NONE;
		else
			next_data_oe = want_oe;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_out <= 12'h000;
			data_oe  <= `SAC_OE_NONE;
		end
		else
		begin
			data_out <= next_data_out;
			data_oe  <= next_data_oe;
		end
	end

endmodule
`default_nettype wire

/* File: design/sac_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sac_params.svh"

module sac_top
#(
	parameter int TICK_DIV = `SAC_TICK_DIV
)
(
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire sac_pkg::sac_ctrl_s ctrl,
	input  wire logic              comp_keep,
	output logic                   conversion_status,
	output logic                   sample_hold,
	output logic      [11:0]       dac_trial,
	output logic      [11:0]       data_out,
	output logic      [11:0]       data_oe
);
	import sac_pkg::*;

	localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

	sac_state_e  state;
	sac_state_e  next_state;
	logic [7:0]  tick_cnt;
	logic [7:0]  next_tick_cnt;
	logic [1:0]  acq_cnt;
	logic [1:0]  next_acq_cnt;
	logic [3:0]  bit_idx;
	logic [3:0]  next_bit_idx;
	logic [11:0] result;
	logic [11:0] next_result;
	logic        short_len;
	logic        next_short_len;
	logic        start_prev;
	logic        next_start_prev;
	logic        next_status;
	logic        next_sample_hold;
	logic [11:0] next_dac_trial;
	logic        start_level;
	logic        start_edge;
	logic        tick;
	logic [3:0]  stop_bit;
	logic        rd_en;

	// ==========================================================
	// Decode helpers
	// Enable-and-select gates both the start level and the read window
	function automatic logic sac_selected(input sac_ctrl_s c);
		return c.chip_enable & ~c.chip_select_n;
	endfunction

	// Short conversions stop after bit four, long ones at bit zero
	function automatic logic [3:0] sac_stop_bit(input logic short_mode);
		return short_mode ? `SAC_SHORT_STOP : `SAC_LONG_STOP;
	endfunction

	// ==========================================================
	// Start detection
	always_comb
	begin
		// Level is a plain gate of the pins; only its last value is kept for the edge
		start_level = sac_selected(ctrl) & ~ctrl.read_convert;
		start_edge = start_level & ~start_prev;
		next_start_prev = start_level;
	end

	// Resets low, so a start level already present at release counts as a start
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			start_prev <= 1'b0;
		else
			start_prev <= next_start_prev;
	end

	// ==========================================================
	// Internal conversion clock
	// Held at zero while idle so every conversion sees the same tick phase
	always_comb
	begin
		tick = (tick_cnt == TICK_LAST);
		if (state == SAC_IDLE || tick)
			next_tick_cnt = 8'h00;
		else
			next_tick_cnt = tick_cnt + 8'h01;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tick_cnt <= 8'h00;
		else
			tick_cnt <= next_tick_cnt;
	end

	// ==========================================================
	// Sequencer
	always_comb
	begin
		next_state     = state;
		next_acq_cnt   = acq_cnt;
		next_bit_idx   = bit_idx;
		next_result    = result;
		next_short_len = short_len;
		stop_bit = sac_stop_bit(short_len);
		// Recaptured on every start, busy or not
		if (start_edge)
			next_short_len = ctrl.length_byte_select;
		unique case (state)
			SAC_IDLE:
			begin
				// Only an idle sequencer reacts; later starts never restart it
				if (start_edge)
				begin
					next_state   = SAC_ACQ;
					next_acq_cnt = 2'h0;
					next_result  = 12'h000;
				end
			end
			SAC_ACQ:
			begin
				// Tracking for two ticks, then the sample is held
				if (tick)
				begin
					if (acq_cnt == `SAC_ACQ_TICKS - 2'h1)
					begin
						next_state   = SAC_CONV;
						next_bit_idx = `SAC_TOP_BIT;
					end
					else
						next_acq_cnt = acq_cnt + 2'h1;
				end
			end
			SAC_CONV:
			begin
				if (tick)
				begin
					next_result[bit_idx] = comp_keep;
					// A late switch to short length ends at the next tick if bit_idx is already at or below four
					if (bit_idx <= stop_bit)
					begin
						next_state = SAC_IDLE;
						if (short_len)
							next_result[3:0] = `SAC_SHORT_TAIL;
					end
					else
						next_bit_idx = bit_idx - 4'h1;
				end
			end
			default:
				next_state = SAC_IDLE;
		endcase
	end

	// The length latch is the only control input the block stores
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state     <= SAC_IDLE;
			acq_cnt   <= 2'h0;
			bit_idx   <= 4'h0;
			result    <= 12'h000;
			short_len <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			acq_cnt   <= next_acq_cnt;
			bit_idx   <= next_bit_idx;
			result    <= next_result;
			short_len <= next_short_len;
		end
	end

	// ==========================================================
	// Status, hold and trial outputs
	// All three follow the next state, so they stay in step with the sequencer
	always_comb
	begin
		next_status = (next_state != SAC_IDLE);
		next_sample_hold = (next_state == SAC_ACQ);
		if (next_state == SAC_CONV)
			next_dac_trial = next_result | (12'h001 << next_bit_idx);
		else
			next_dac_trial = next_result;
		// Closed a cycle ahead of status so no pin is live while busy
		rd_en = ctrl.read_convert & ~next_status & sac_selected(ctrl);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			conversion_status <= 1'b0;
			sample_hold       <= 1'b0;
			dac_trial         <= 12'h000;
		end
		else
		begin
			conversion_status <= next_status;
			sample_hold       <= next_sample_hold;
			dac_trial         <= next_dac_trial;
		end
	end

	// ==========================================================
	// Output drivers
	// Fed the next result so the final bit is on the pins at the first enabled edge
	sac_out_stage u_out
	(
		.clk_sys            (clk_sys),
		.rst_n              (rst_n),
		.rd_en              (rd_en),
		.width_select       (ctrl.width_select),
		.length_byte_select (ctrl.length_byte_select),
		.result             (next_result),
		.data_out           (data_out),
		.data_oe            (data_oe)
	);

endmodule
`default_nettype wire

/* File: tb/sac_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_top_chk
#(
	parameter int TICK_DIV = 4
)
(
	input wire logic              clk_sys,
	input wire logic              rst_n,
	input wire sac_pkg::sac_ctrl_s ctrl,
	input wire logic              comp_keep,
	input wire logic              conversion_status,
	input wire logic              sample_hold,
	input wire logic [11:0]       dac_trial,
	input wire logic [11:0]       data_out,
	input wire logic [11:0]       data_oe
);
	import sac_pkg::*;
	localparam int ACQ1 = 2 * TICK_DIV - 1;
	localparam int S1 = 10 * TICK_DIV - 1;
	localparam int L3 = 4 * TICK_DIV - 1;
	logic go;
	assign go = ctrl.chip_enable & ~ctrl.chip_select_n & ~ctrl.read_convert;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_start_begins: assert property ($rose(go) && !conversion_status |=> conversion_status)
		else $error("start lost");
	a_busy_quiet: assert property (conversion_status |-> data_oe == 12'h000)
		else $error("driven while busy");
	a_read_gate: assert property (data_oe != 12'h000 |->
		$past(ctrl.read_convert & ctrl.chip_enable & ~ctrl.chip_select_n)) else $error("read gate");
	a_oe_mode: assert property (data_oe != 12'h000 |-> data_oe == ($past(ctrl.width_select) ?
		12'hfff : $past(ctrl.length_byte_select) ? 12'h0ff : 12'hff0)) else $error("enable mode");
	a_low_nibble: assert property (data_oe == 12'h0ff |-> data_out[7:4] == 4'h0)
		else $error("bits 7:4 not zero");
	a_break_make: assert property (data_oe != 12'h000 && $past(data_oe) != 12'h000
		|-> data_oe == $past(data_oe)) else $error("no break before make");
	a_acq_span: assert property ($rose(conversion_status) |-> sample_hold ##ACQ1 sample_hold ##1 !sample_hold)
		else $error("acquire span");
	// Either length is legal; a late recapture is never driven by the bench
	a_conv_span: assert property ($rose(conversion_status) |-> ##S1 conversion_status ##1
		(!conversion_status or (conversion_status ##L3 conversion_status ##1 !conversion_status)))
		else $error("conversion span");
	c_start: cover property ($rose(conversion_status));
	c_full: cover property (data_oe == 12'hfff);
	c_low: cover property (data_oe == 12'h0ff);
endmodule
bind sac_top sac_top_chk #(.TICK_DIV(TICK_DIV)) i_chk (.clk_sys, .rst_n, .ctrl, .comp_keep,
	.conversion_status, .sample_hold, .dac_trial, .data_out, .data_oe);
`default_nettype wire

/* File: tb/sac_comp_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_comp_model
(
	input  wire logic [11:0] dac_trial,
	input  wire logic [11:0] level,
	output logic             comp_keep
);
	// Ideal comparator, so a full result equals the level
	assign comp_keep = dac_trial <= level;
endmodule
`default_nettype wire

/* File: tb/sac_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_top_tb;
	import sac_pkg::*;
	localparam int TD = 2;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	sac_ctrl_s   ctrl = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
	logic [11:0] level = 12'h000;
	logic        comp_keep;
	logic        conversion_status;
	logic        sample_hold;
	logic [11:0] dac_trial;
	logic [11:0] data_out;
	logic [11:0] data_oe;
	int          err_total = 0;
	int          comparisons = 0;
	always #5 clk_sys = ~clk_sys;
	sac_top #(.TICK_DIV(TD)) i_dut (.clk_sys, .rst_n, .ctrl, .comp_keep, .conversion_status,
		.sample_hold, .dac_trial, .data_out, .data_oe);
	sac_comp_model i_comp (.dac_trial, .level, .comp_keep);
	task automatic chk(logic [11:0] seen, logic [11:0] exp, string msg);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic put(logic ce, logic cs_n, logic rc, logic w, logic lbs);
		@(posedge clk_sys);
		#1;
		ctrl = '{ce, cs_n, rc, w, lbs};
	endtask
	function automatic logic [11:0] expect_res(logic [11:0] lvl, logic short);
		return short ? {lvl[11:4], 4'h8} : lvl;
	endfunction
	// g picks the input that arrives last
	task automatic convert(int g, logic lbs, logic rec, logic [11:0] lvl);
		time t0;
		logic [11:0] res;
		res = expect_res(lvl, lbs | rec);
		level = lvl;
		put(g != 0, g == 1, g == 2, 1'b1, lbs);
		repeat (5) @(posedge clk_sys);
		put(1'b1, 1'b0, 1'b0, 1'b1, lbs);
		@(posedge clk_sys);
		#1;
		t0 = $time;
		chk(conversion_status, 1'b1, "no start");
		if (rec)
		begin
			put(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
			put(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		end
		put(1'b1, 1'b0, 1'b1, 1'b1, ~lbs);
		chk(data_oe, 12'h000, "driven while busy");
		while (conversion_status === 1'b1 && $time - t0 < 1000)
			@(posedge clk_sys) #1;
		chk(12'(($time - t0) / 10), 12'(TD * ((lbs | rec) ? 10 : 14)), "length");
		chk(data_oe, 12'hfff, "read window at status fall");
		chk(data_out, res, "data at status fall");
		for (int m = 0; m < 3; m++)
		begin
			put(1'b1, 1'b0, 1'b1, m == 0, m == 2);
			@(posedge clk_sys);
			#1;
			chk(data_oe, m == 0 ? 12'hfff : 12'h000, "no dead cycle");
			@(posedge clk_sys);
			#1;
			chk(data_oe, m == 0 ? 12'hfff : m == 1 ? 12'hff0 : 12'h0ff, "enables");
			chk(data_out, m == 2 ? {8'h00, res[3:0]} : res, "read data");
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		void'($urandom(64892));
		repeat (3) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		for (int i = 0; i < 9; i++)
			convert(i % 3, 1'($urandom), 1'b0, 12'($urandom));
		$display("test random conversions done");
		convert(2, 1'b0, 1'b1, 12'hfff);
		convert(0, 1'b1, 1'b0, 12'h000);
		$display("test recapture and corners done");
		tally_and_finish();
	end
	// Eleven conversions need under a thousand cycles
	initial
	begin
		#100000;
		err_total++;
		$display("mismatch at %0t: watchdog", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
